// ---- kkr_defs.vh ----
/*
 * Constants of the keypad and knob request logic: bus decode, latch bit
 * positions, timing figures and their cycle counts at the system clock.
 * Assumes inclusion by bare name and a 25 MHz clk_sys_i.
 */
`ifndef KKR_DEFS_VH
`define KKR_DEFS_VH

// System clock rate
`define KKR_CLK_KHZ        25000

// Timing figures as printed, then cycles
`define KKR_KEYDOWN_MS     20
`define KKR_REPEAT_MS      500
`define KKR_REPEAT_HZ      5
`define KKR_RELEASE_MS     50
`define KKR_WINDOW_MS      70
// Cycle counts of the figures above at 25 MHz, sized to the timer width
`define KKR_KEYDOWN_CYC    24'h07_A120
`define KKR_REPEAT_CYC     24'hBE_BC20
`define KKR_RATE_CYC       24'h4C_4B40
`define KKR_RELEASE_CYC    24'h13_12D0
`define KKR_WINDOW_CYC     24'h1A_B3F0
`define KKR_TIMER_W        24

// I/O addresses and function codes
`define KKR_ADDR_PANEL     5'h06
`define KKR_ADDR_LED       5'h04
`define KKR_FUNC_LATCH     2'h1
`define KKR_FUNC_CLEAR     2'h2
`define KKR_FUNC_READ      2'h3

// Latch bits
`define KKR_LOCK_LATCH     0
`define KKR_LOCK_BIT       7
`define KKR_ENTRY_LATCH    1
`define KKR_ENTRY_BIT      0
`define KKR_PRESET_LATCH   2
`define KKR_PRESET_BIT     0
`define KKR_UNUSED_LATCH   3
`define KKR_UNUSED_BIT     7
`define KKR_LATCH_RESET    8'h00
// Synchroniser reset: idle level of each pin, knob phases low
`define KKR_PIN_IDLE       10'h27F

// Read word bits
`define KKR_RD_KEY_BIT     0
`define KKR_RD_COL_LSB     1
`define KKR_RD_ROW_LSB     4
`define KKR_RD_KNOB_BIT    7

`endif

// ---- kkr_sync.v ----
/*
 * Two-stage synchroniser for a group of level inputs.
 * Assumes inputs are independent levels; no bus coherence is implied.
 */
`timescale 1ns/100ps
module kkr_sync #(
    parameter W = 1
) (
    input  wire         clk_sys_i,
    input  wire         reset_i,
    input  wire [W-1:0] async_i,
    input  wire [W-1:0] reset_val_i,
    output reg  [W-1:0] sync_o
);
    reg [W-1:0] meta_q;

    always @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            meta_q <= reset_val_i;
            sync_o <= reset_val_i;
        end
        else
        begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule

// ---- kkr_oneshot.v ----
/*
 * Non-retriggerable one-shot built as a down counter.
 * Assumes fire_i is a pulse or level on clk_sys_i; hold_i keeps it idle.
 */
`timescale 1ns/100ps
module kkr_oneshot #(
    parameter [23:0] CYCLES = 24'h00_0001
) (
    input  wire clk_sys_i,
    input  wire reset_i,
    input  wire hold_i,
    input  wire fire_i,
    output reg  active_o,
    output reg  done_o
);
    reg [23:0] count_q;

    always @(posedge clk_sys_i)
    begin
        if (reset_i || hold_i)
        begin
            active_o <= 1'b0;
            done_o   <= 1'b0;
            count_q  <= 24'h00_0000;
        end
        else if (!active_o)
        begin
            done_o <= 1'b0;
            if (fire_i)
            begin
                // Triggers while running are ignored
                active_o <= 1'b1;
                count_q  <= CYCLES - 24'h00_0001;
            end
        end
        else if (count_q == 24'h00_0000)
        begin
            active_o <= 1'b0;
            done_o   <= 1'b1;
        end
        else
        begin
            count_q <= count_q - 24'h00_0001;
        end
    end
endmodule

// ---- kkr_top.v ----
/*
 * Keypad and rotary knob request logic: service request, key repeat,
 * key-release debounce, knob counter with count window, panel latches
 * and strobe decode.
 * Assumes the processor bus is synchronous to clk_sys_i and that key
 * row and column codes come already priority encoded, low-true.
 */
`timescale 1ns/100ps
`include "kkr_defs.vh"

module kkr_top #(
    parameter [23:0] KEYDOWN_CYC = `KKR_KEYDOWN_CYC,
    parameter [23:0] REPEAT_CYC  = `KKR_REPEAT_CYC,
    parameter [23:0] RATE_CYC    = `KKR_RATE_CYC,
    parameter [23:0] RELEASE_CYC = `KKR_RELEASE_CYC,
    parameter [23:0] WINDOW_CYC  = `KKR_WINDOW_CYC
) (
    input  wire        clk_sys_i,
    input  wire        reset_i,
    input  wire        io_select_strobe_i,
    input  wire [4:0]  io_addr_i,
    input  wire [1:0]  io_func_i,
    input  wire        io_write_i,
    input  wire [7:0]  io_data_i,
    input  wire        key_down_n_i,
    input  wire [2:0]  key_row_n_i,
    input  wire [2:0]  key_col_n_i,
    input  wire        knob_clock_i,
    input  wire        knob_dir_i,
    input  wire        preset_request_n_i,
    output reg         service_request_n_o,
    output reg         read_valid_o,
    output reg  [7:0]  read_key_o,
    output reg  [7:0]  read_count_o,
    output reg  [28:0] led_o,
    output reg         keypad_lockout_o,
    output reg         preset_request_n_o,
    output reg         repeat_active_o,
    output reg         key_disable_o
);
    // Repeat oscillator states
    localparam [1:0] RPT_IDLE = 2'b01;
    localparam [1:0] RPT_RUN  = 2'b10;

    function strobe_hit;
        input [4:0] addr;
        input [1:0] func;
        input [4:0] want_addr;
        input [1:0] want_func;
        begin
            strobe_hit = (addr == want_addr) && (func == want_func);
        end
    endfunction

    wire [9:0] pins_s;
    wire       key_down_n_s;
    wire [2:0] row_n_s;
    wire [2:0] col_n_s;
    wire       knob_clk_s;
    wire       knob_dir_s;
    wire       preset_n_s;

    kkr_sync #(
        .W (10)
    ) u_sync (
        .clk_sys_i   (clk_sys_i),
        .reset_i     (reset_i),
        .async_i     ({preset_request_n_i, knob_dir_i, knob_clock_i,
                       key_col_n_i, key_row_n_i, key_down_n_i}),
        // Idle levels, so no false knob edge follows reset
        .reset_val_i (`KKR_PIN_IDLE),
        .sync_o      (pins_s)
    );

    assign key_down_n_s = pins_s[0];
    assign row_n_s      = pins_s[3:1];
    assign col_n_s      = pins_s[6:4];
    assign knob_clk_s   = pins_s[7];
    assign knob_dir_s   = pins_s[8];
    assign preset_n_s   = pins_s[9];

    // Strobe decode
    reg  sel_q;
    wire sel_edge = io_select_strobe_i & ~sel_q;
    wire wr_lock  = sel_edge & io_write_i
                  & strobe_hit(io_addr_i, io_func_i, `KKR_ADDR_PANEL, `KKR_FUNC_LATCH);
    wire wr_led   = sel_edge & io_write_i & (io_addr_i == `KKR_ADDR_LED)
                  & (io_func_i != 2'h0);
    wire clr_stb  = sel_edge
                  & strobe_hit(io_addr_i, io_func_i, `KKR_ADDR_PANEL, `KKR_FUNC_CLEAR);
    wire rd_stb   = sel_edge & ~io_write_i
                  & strobe_hit(io_addr_i, io_func_i, `KKR_ADDR_PANEL, `KKR_FUNC_READ);

    // Panel latches
    reg [7:0] latch_q [0:3];
    wire lockout     = latch_q[`KKR_LOCK_LATCH][`KKR_LOCK_BIT];
    wire knob_enable = latch_q[`KKR_ENTRY_LATCH][`KKR_ENTRY_BIT];
    wire preset_ok   = latch_q[`KKR_PRESET_LATCH][`KKR_PRESET_BIT];

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_latch
            always @(posedge clk_sys_i)
            begin
                if (reset_i)
                    latch_q[gi] <= `KKR_LATCH_RESET;
                else if ((gi == 0 && wr_lock)
                         || (gi != 0 && wr_led && io_func_i == gi))
                    latch_q[gi] <= io_data_i;
            end
        end
    endgenerate

    // Key path
    wire key_down = ~key_down_n_s;
    reg  key_down_q;
    wire key_release = key_down_q & ~key_down;
    reg  key_request_q;
    reg  disable_q;
    wire qual_active;
    wire qual_done;
    wire valid_key = qual_done & key_down;
    wire hold_cond = key_down & ~lockout;
    wire rel_active;
    // Start cycle counted so the enable never drops between hold and timer
    wire dis_enable = hold_cond | rel_active | key_release;

    kkr_oneshot #(
        .CYCLES (KEYDOWN_CYC)
    ) u_qual (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .hold_i    (lockout | disable_q),
        .fire_i    (key_down),
        .active_o  (qual_active),
        .done_o    (qual_done)
    );

    kkr_oneshot #(
        .CYCLES (RELEASE_CYC)
    ) u_release (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .hold_i    (1'b0),
        .fire_i    (key_release),
        .active_o  (rel_active),
        .done_o    ()
    );

    always @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            key_down_q <= 1'b0;
            disable_q  <= 1'b0;
        end
        else
        begin
            key_down_q <= key_down;
            if (!dis_enable)
                disable_q <= 1'b0;
            else if (valid_key)
                disable_q <= 1'b1;
        end
    end

    // Repeat: delay timer, then 5 Hz one-cycle pulses
    wire rpt_done;
    reg  repeat_q;
    reg  [1:0] rpt_state_q;
    reg  [23:0] rate_q;
    reg  repeat_pulse;

    kkr_oneshot #(
        .CYCLES (REPEAT_CYC)
    ) u_repeat (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .hold_i    (1'b0),
        .fire_i    (valid_key),
        .active_o  (),
        .done_o    (rpt_done)
    );

    always @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            repeat_q     <= 1'b0;
            rpt_state_q  <= RPT_IDLE;
            rate_q       <= 24'h00_0000;
            repeat_pulse <= 1'b0;
        end
        else
        begin
            if (!key_down)
                repeat_q <= 1'b0;
            else if (rpt_done)
                repeat_q <= 1'b1;
            repeat_pulse <= 1'b0;
            case (rpt_state_q)
                RPT_IDLE:
                begin
                    rate_q <= 24'h00_0000;
                    if (repeat_q)
                        rpt_state_q <= RPT_RUN;
                end
                RPT_RUN:
                begin
                    if (!repeat_q)
                        rpt_state_q <= RPT_IDLE;
                    else if (rate_q == RATE_CYC - 24'h00_0001)
                    begin
                        rate_q       <= 24'h00_0000;
                        // One cycle, far below any service latency
                        repeat_pulse <= 1'b1;
                    end
                    else
                        rate_q <= rate_q + 24'h00_0001;
                end
                default:
                    rpt_state_q <= RPT_IDLE;
            endcase
        end
    end

    wire key_request_d = valid_key | (repeat_pulse & repeat_q)
                       | (key_request_q & ~clr_stb);

    // Knob path
    reg        knob_clk_q;
    wire       knob_edge = knob_clk_s & ~knob_clk_q;
    reg        knob_request_q;
    wire       win_done;
    wire [7:0] count_q;
    wire [2:0] carry;
    wire       count_en = knob_edge & ~knob_request_q;
    wire       count_up = knob_dir_s;

    assign carry[0] = count_en;

    generate
        for (gi = 0; gi < 2; gi = gi + 1)
        begin : g_count
            reg [3:0] nib_q;
            wire      term = count_up ? (nib_q == 4'hF) : (nib_q == 4'h0);
            assign carry[gi+1]         = carry[gi] & term;
            assign count_q[gi*4 +: 4]  = nib_q;
            always @(posedge clk_sys_i)
            begin
                if (reset_i || clr_stb)
                    nib_q <= 4'h0;
                else if (carry[gi])
                    nib_q <= count_up ? nib_q + 4'h1 : nib_q - 4'h1;
            end
        end
    endgenerate

    kkr_oneshot #(
        .CYCLES (WINDOW_CYC)
    ) u_window (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .hold_i    (1'b0),
        .fire_i    (knob_edge & ~knob_request_q),
        .active_o  (),
        .done_o    (win_done)
    );

    wire knob_request_d = (win_done & knob_enable)
                        | (knob_request_q & ~clr_stb);

    // Request flags, readback and outputs
    always @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            sel_q               <= 1'b0;
            knob_clk_q          <= 1'b0;
            key_request_q       <= 1'b0;
            knob_request_q      <= 1'b0;
            service_request_n_o <= 1'b1;
            read_valid_o        <= 1'b0;
            read_key_o          <= 8'h00;
            read_count_o        <= 8'h00;
            led_o               <= 29'h0000_0000;
            keypad_lockout_o    <= 1'b0;
            preset_request_n_o  <= 1'b1;
            repeat_active_o     <= 1'b0;
            key_disable_o       <= 1'b0;
        end
        else
        begin
            sel_q               <= io_select_strobe_i;
            knob_clk_q          <= knob_clk_s;
            key_request_q       <= key_request_d;
            knob_request_q      <= knob_request_d;
            service_request_n_o <= ~(key_request_d | knob_request_d);
            read_valid_o        <= rd_stb;
            if (rd_stb)
            begin
                read_key_o[`KKR_RD_KEY_BIT]                <= ~key_request_q;
                read_key_o[`KKR_RD_COL_LSB +: 3]           <= ~col_n_s;
                read_key_o[`KKR_RD_ROW_LSB +: 3]           <= ~row_n_s;
                read_key_o[`KKR_RD_KNOB_BIT]               <= ~knob_request_q;
                read_count_o                               <= count_q;
            end
            led_o <= {latch_q[3][6:0], latch_q[2][7:1],
                      latch_q[1], latch_q[0][6:0]};
            keypad_lockout_o   <= lockout;
            // Preset only passes while the latch allows it
            preset_request_n_o <= ~(~preset_n_s & preset_ok);
            repeat_active_o    <= repeat_q;
            // Done cycle bridges the gap before the disable flag sets
            key_disable_o      <= disable_q | qual_active | qual_done;
        end
    end
endmodule

// ---- kkr_top_asserts.sv ----
/* Port checker for kkr_top: bus decode, latches, read word, key timers.
   Assumes binding onto kkr_top and a bus master keeping strobe gaps. */
`timescale 1ns/100ps
module kkr_top_asserts (
    input wire logic        clk_sys_i,
    input wire logic        reset_i,
    input wire logic        io_select_strobe_i,
    input wire logic [4:0]  io_addr_i,
    input wire logic [1:0]  io_func_i,
    input wire logic        io_write_i,
    input wire logic [7:0]  io_data_i,
    input wire logic        key_down_n_i,
    input wire logic        service_request_n_o,
    input wire logic        read_valid_o,
    input wire logic [7:0]  read_key_o,
    input wire logic [7:0]  read_count_o,
    input wire logic [28:0] led_o,
    input wire logic        keypad_lockout_o,
    input wire logic        repeat_active_o,
    input wire logic        key_disable_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    sequence s_take(w, a, f);
        $rose(io_select_strobe_i) && io_write_i == w && io_addr_i == a && io_func_i == f;
    endsequence
    property p_rd_answer;
        s_take(1'b0, 5'h06, 2'h3) |=> read_valid_o;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    property p_rd_cause;
        read_valid_o |-> $past(io_select_strobe_i) && !$past(io_write_i)
                         && $past(io_addr_i) == 5'h06 && $past(io_func_i) == 2'h3;
    endproperty
    a_rd_cause: assert property (p_rd_cause) else $error("read answer without read");
    // Latch loads on the taking edge, the output register one edge later
    property p_lock;
        s_take(1'b1, 5'h06, 2'h1) |=> ##1 keypad_lockout_o == $past(io_data_i[7], 2);
    endproperty
    a_lock: assert property (p_lock) else $error("lockout latch wrong");
    property p_led;
        s_take(1'b1, 5'h04, 2'h1) |=> ##1 led_o[14:7] == $past(io_data_i, 2);
    endproperty
    a_led: assert property (p_led) else $error("entry latch wrong");
    property p_srq_word;
        read_valid_o |-> $past(service_request_n_o) == (read_key_o[0] & read_key_o[7]);
    endproperty
    a_srq_word: assert property (p_srq_word) else $error("request bits disagree");
    property p_word_hold;
        !read_valid_o |-> $stable({read_key_o, read_count_o});
    endproperty
    a_word_hold: assert property (p_word_hold) else $error("read word moved");
    property p_repeat_blocks;
        repeat_active_o |-> key_disable_o;
    endproperty
    a_repeat_blocks: assert property (p_repeat_blocks) else $error("repeat without block");
    property p_release;
        $fell(key_disable_o) |-> $past(key_down_n_i, 4);
    endproperty
    a_release: assert property (p_release) else $error("detection reopened early");
endmodule

// ---- kkr_cpu_model.sv ----
/* Processor model on the panel I/O bus.
   Assumes a free-running clk_sys_i and one access at a time. */
`timescale 1ns/100ps
module kkr_cpu_model (
    input  wire logic       clk_sys_i,
    input  wire logic       read_valid_i,
    input  wire logic [7:0] read_key_i,
    input  wire logic [7:0] read_count_i,
    output logic            strobe_o,
    output logic [4:0]      addr_o,
    output logic [1:0]      func_o,
    output logic            write_o,
    output logic [7:0]      data_o
);
    logic       got_valid;
    logic [7:0] got_key;
    logic [7:0] got_count;
    initial
    begin
        strobe_o = 1'b0;
        addr_o = 5'h00;
        func_o = 2'h0;
        write_o = 1'b0;
        data_o = 8'h00;
    end
    task access(input logic w, input logic [4:0] a, input logic [1:0] f, input logic [7:0] d);
        @(posedge clk_sys_i);
        strobe_o <= 1'b1;
        write_o <= w;
        addr_o <= a;
        func_o <= f;
        data_o <= d;
        @(posedge clk_sys_i);
        // Released address, function and data lines show the inverse; write_o keeps its old value
        strobe_o <= 1'b0;
        addr_o <= ~a;
        func_o <= ~f;
        data_o <= ~d;
        @(posedge clk_sys_i);
        got_valid = read_valid_i;
        got_key = read_key_i;
        got_count = read_count_i;
    endtask
    task wr(input logic [4:0] a, input logic [1:0] f, input logic [7:0] d);
        access(1'b1, a, f, d);
    endtask
    task rd;
        access(1'b0, 5'h06, 2'h3, 8'h00);
    endtask
    task clr;
        access(1'b0, 5'h06, 2'h2, 8'h00);
    endtask
endmodule

// ---- kkr_testbench.sv ----
/* Self-checking bench for kkr_top with shortened timer counts.
   Assumes kkr_cpu_model drives the bus; keys and knob driven here. */
`timescale 1ns/100ps
module testbench;
    logic        clk_sys_i;
    logic        reset_i;
    logic        key_down_n;
    logic [2:0]  key_row_n;
    logic [2:0]  key_col_n;
    logic        knob_clock;
    logic        knob_dir;
    logic        preset_n;
    wire         strobe;
    wire  [4:0]  addr;
    wire  [1:0]  func;
    wire         wr;
    wire  [7:0]  data;
    wire         srq_n;
    wire         read_valid;
    wire  [7:0]  read_key;
    wire  [7:0]  read_count;
    wire  [28:0] led;
    wire         lockout;
    wire         preset_out_n;
    wire         repeat_act;
    wire         key_dis;
    int          fail_count;
    int          n_tests;
    kkr_top #(.KEYDOWN_CYC(24'h00_0014), .REPEAT_CYC(24'h00_0032), .RATE_CYC(24'h00_001E),
              .RELEASE_CYC(24'h00_000A), .WINDOW_CYC(24'h00_0028)) uut (
        .clk_sys_i(clk_sys_i), .reset_i(reset_i), .io_select_strobe_i(strobe), .io_addr_i(addr),
        .io_func_i(func), .io_write_i(wr), .io_data_i(data), .key_down_n_i(key_down_n),
        .key_row_n_i(key_row_n), .key_col_n_i(key_col_n), .knob_clock_i(knob_clock),
        .knob_dir_i(knob_dir), .preset_request_n_i(preset_n), .service_request_n_o(srq_n),
        .read_valid_o(read_valid), .read_key_o(read_key), .read_count_o(read_count), .led_o(led),
        .keypad_lockout_o(lockout), .preset_request_n_o(preset_out_n), .repeat_active_o(repeat_act),
        .key_disable_o(key_dis));
    kkr_cpu_model cpu (.clk_sys_i(clk_sys_i), .read_valid_i(read_valid), .read_key_i(read_key),
        .read_count_i(read_count), .strobe_o(strobe), .addr_o(addr), .func_o(func), .write_o(wr),
        .data_o(data));
    initial clk_sys_i = 1'b0;
    always #20 clk_sys_i = ~clk_sys_i;
    task chk(input logic [39:0] got, input logic [39:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task idle(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    task wait_srq(input int n);
        for (int i = 0; i < n && srq_n !== 1'b0; i++) @(posedge clk_sys_i);
    endtask
    task knob(input logic dir);
        knob_dir <= dir;
        idle(3);
        knob_clock <= 1'b1;
        idle(3);
        knob_clock <= 1'b0;
        idle(3);
    endtask
    task final_report;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        repeat (3000) @(posedge clk_sys_i);
        fail_count++;
        final_report();
    end
    initial
    begin
        fail_count = 0;
        n_tests = 0;
        reset_i = 1'b1;
        key_down_n = 1'b1;
        key_row_n = 3'b111;
        key_col_n = 3'b111;
        knob_clock = 1'b0;
        knob_dir = 1'b0;
        preset_n = 1'b1;
        idle(3);
        reset_i <= 1'b0;
        idle(2);
        chk(srq_n, 1);
        chk({led, lockout, repeat_act, key_dis, read_valid}, 0);
        cpu.wr(5'h06, 2'h1, 8'h7F);
        cpu.wr(5'h04, 2'h1, 8'hA5);
        cpu.wr(5'h04, 2'h2, 8'h03);
        cpu.wr(5'h04, 2'h3, 8'h5A);
        cpu.wr(5'h04, 2'h0, 8'hFF);
        preset_n <= 1'b0;
        idle(5);
        chk(led, {7'h5A, 7'h01, 8'hA5, 7'h7F});
        chk(lockout, 0);
        chk(preset_out_n, 0);
        key_row_n <= 3'b101;
        key_col_n <= 3'b110;
        key_down_n <= 1'b0;
        wait_srq(60);
        chk(srq_n, 0);
        chk(key_dis, 1);
        cpu.rd();
        chk(cpu.got_valid, 1);
        chk(cpu.got_key, 8'hA2);
        cpu.clr();
        chk(srq_n, 1);
        for (int i = 0; i < 80 && repeat_act !== 1'b1; i++) @(posedge clk_sys_i);
        chk(repeat_act, 1);
        wait_srq(40);
        chk(srq_n, 0);
        cpu.clr();
        idle(3);
        chk(srq_n, 1);
        key_down_n <= 1'b1;
        idle(6);
        chk(key_dis, 1);
        idle(20);
        chk(key_dis, 0);
        chk(repeat_act, 0);
        cpu.wr(5'h06, 2'h1, 8'h80);
        key_down_n <= 1'b0;
        idle(60);
        chk(lockout, 1);
        chk(srq_n, 1);
        key_down_n <= 1'b1;
        idle(20);
        cpu.wr(5'h06, 2'h1, 8'h00);
        key_row_n <= 3'b111;
        key_col_n <= 3'b111;
        knob(1'b1);
        knob(1'b1);
        knob(1'b1);
        knob(1'b0);
        wait_srq(60);
        chk(srq_n, 0);
        knob(1'b1);
        knob(1'b1);
        cpu.rd();
        chk(cpu.got_key, 8'h01);
        chk(cpu.got_count, 8'h02);
        cpu.clr();
        chk(srq_n, 1);
        cpu.rd();
        chk(cpu.got_count, 8'h00);
        knob(1'b0);
        wait_srq(60);
        cpu.rd();
        chk(cpu.got_count, 8'hFF);
        cpu.clr();
        cpu.wr(5'h04, 2'h1, 8'hA4);
        knob(1'b1);
        idle(60);
        chk(srq_n, 1);
        cpu.rd();
        chk(cpu.got_count, 8'h01);
        cpu.clr();
        final_report();
    end
endmodule
bind kkr_top kkr_top_asserts u_chk (.*);
